// [include/uish_pkg.sv]
// Register map, field positions and reset values of the interrupt/status/holding block
package uish_pkg;
	// Word byte offsets (register offsets chosen for this block)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_IEN    = 8'h08;
	localparam logic [7:0] OFS_IDIS   = 8'h0C;
	localparam logic [7:0] OFS_IMASK  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_RXHOLD = 8'h18;
	localparam logic [7:0] OFS_TXHOLD = 8'h1C;
	// Status and mask bit positions
	localparam int B_RX_CHAR_AVAILABLE = 0;
	localparam int B_TX_HOLDING_FREE = 1;
	localparam int B_BRK   = 2;
	localparam int B_RXDMA = 3;
	localparam int B_TXDMA = 4;
	localparam int B_OVR   = 5;
	localparam int B_FRM   = 6;
	localparam int B_PAR   = 7;
	localparam int B_TMO   = 8;
	localparam int B_TXE   = 9;
	localparam int B_MDM   = 10;
	localparam int NSRC    = 11;
	localparam int CHW     = 9;
	// Control command bit positions
	localparam int C_RSTRX  = 2;
	localparam int C_RSTTX  = 3;
	localparam int C_RXEN   = 4;
	localparam int C_RXDIS  = 5;
	localparam int C_TXEN   = 6;
	localparam int C_TXDIS  = 7;
	localparam int C_CLRSTA = 8;
	localparam int C_STTBRK = 9;
	localparam int C_STPBRK = 10;
	localparam int C_STTTO  = 11;
	// Reset values
	localparam logic [NSRC-1:0] MASK_RST   = 11'h000;
	localparam logic [NSRC-1:0] STATUS_RST = 11'h018;
endpackage : uish_pkg

// [core/uish_top.sv]
// Interrupt mask, channel status and character holding registers of a serial channel
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module uish_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Classic Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// Receiver side events, one-cycle pulses from same-clock logic; timeout_zero_i is a level
	input  wire logic        rx_char_valid_i,
	input  wire logic [8:0]  rx_char_i,
	input  wire logic        rx_frame_err_i,
	input  wire logic        rx_parity_err_i,
	input  wire logic        rx_break_evt_i,
	input  wire logic        rx_timeout_evt_i,
	input  wire logic        timeout_zero_i,
	input  wire logic        modem_delta_i,
	// DMA end-of-transfer levels
	input  wire logic        rx_dma_done_i,
	input  wire logic        tx_dma_done_i,
	// Transmit shifter handshake
	output logic             tx_char_valid_o,
	output logic      [8:0]  char_to_send_o,
	input  wire logic        tx_shift_ready_i,
	input  wire logic        tx_shift_busy_i,
	input  wire logic        tx_break_active_i,
	// Enable levels, commands to the serial engine and interrupt level; break stop and timeout start are one-cycle pulses
	output logic             rx_enabled_o,
	output logic             tx_enabled_o,
	output logic             break_start_o,
	output logic             break_stop_o,
	output logic             timeout_start_o,
	output logic             irq_o
);
	logic [uish_pkg::NSRC-1:0] mask_r;
	logic                      rx_char_available_r;
	logic                      brk_r;
	logic                      ovr_r;
	logic                      frm_r;
	logic                      par_r;
	logic                      tmo_r;
	logic                      mdm_r;
	logic                      rx_take;
	logic                      tmo_restart;
	logic [uish_pkg::NSRC-1:0] status;
	logic [uish_pkg::CHW-1:0]  rx_hold_r;
	logic [uish_pkg::CHW-1:0]  tx_hold_r;
	logic                      tx_full_r;
	logic                      brk_pend_r;
	logic                      rx_en_r;
	logic                      tx_en_r;
	logic                      ack_r;
	logic                      req;
	logic                      wr;
	logic                      rd;
	logic                      mapped;
	logic [31:0]               rd_nxt;
	logic                      cmd_wr;
	logic                      clr_sta;
	logic                      rx_off;
	logic                      tx_off;
	logic                      tx_on;
	logic                      rhr_rd;
	logic                      thr_wr;
	logic                      tx_take;

	// Address match against one register offset; byte lanes are ignored,
	// so every access is treated as a full word
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Sticky flag next value: a set in the clearing cycle survives, so no
	// event is lost when software clears at the wrong moment
	function automatic logic keep_or_set(input logic set, input logic cur, input logic clr);
		return set || (cur && !clr);
	endfunction

	// Bus decode; ack one cycle after strobe, dropped the next cycle
	assign req     = wb_cyc_i && wb_stb_i && !ack_r && !wb_err_o;
	assign wr      = req && wb_we_i;
	assign rd      = req && !wb_we_i;
	assign mapped  = hit(wb_adr_i, uish_pkg::OFS_CTRL) || hit(wb_adr_i, uish_pkg::OFS_IEN)
		|| hit(wb_adr_i, uish_pkg::OFS_IDIS) || hit(wb_adr_i, uish_pkg::OFS_IMASK)
		|| hit(wb_adr_i, uish_pkg::OFS_STATUS) || hit(wb_adr_i, uish_pkg::OFS_RXHOLD)
		|| hit(wb_adr_i, uish_pkg::OFS_TXHOLD);
	assign cmd_wr  = wr && hit(wb_adr_i, uish_pkg::OFS_CTRL);
	assign clr_sta = cmd_wr && wb_dat_i[uish_pkg::C_CLRSTA];
	assign rx_off  = cmd_wr && (wb_dat_i[uish_pkg::C_RXDIS] || wb_dat_i[uish_pkg::C_RSTRX]);
	assign tx_off  = cmd_wr && (wb_dat_i[uish_pkg::C_TXDIS] || wb_dat_i[uish_pkg::C_RSTTX]);
	assign tx_on   = cmd_wr && wb_dat_i[uish_pkg::C_TXEN] && !tx_off;
	assign rhr_rd  = rd && hit(wb_adr_i, uish_pkg::OFS_RXHOLD);
	assign thr_wr  = wr && hit(wb_adr_i, uish_pkg::OFS_TXHOLD) && tx_en_r;
	assign tx_take = tx_full_r && tx_shift_ready_i;
	assign rx_take = rx_char_valid_i && rx_en_r;
	assign tmo_restart = cmd_wr && wb_dat_i[uish_pkg::C_STTTO];

	// Ack strobe; the master keeps cyc and stb up, so ack_r masks a retake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && mapped;
		end
	end
	assign wb_ack_o = ack_r;

	// Error strobe for holes in the map; it also masks a retake of the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_err_o <= 1'b0;
		end else begin
			wb_err_o <= req && !mapped;
		end
	end

	// Mask set/clear; a one in both enable and disable writes is impossible per cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r <= uish_pkg::MASK_RST;
		end else if (wr && hit(wb_adr_i, uish_pkg::OFS_IEN)) begin
			mask_r <= mask_r | wb_dat_i[uish_pkg::NSRC-1:0];
		end else if (wr && hit(wb_adr_i, uish_pkg::OFS_IDIS)) begin
			mask_r <= mask_r & ~wb_dat_i[uish_pkg::NSRC-1:0];
		end
	end

	// Receiver enable state; disable wins over enable in one write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_en_r <= 1'b0;
		end else if (rx_off) begin
			rx_en_r <= 1'b0;
		end else if (cmd_wr && wb_dat_i[uish_pkg::C_RXEN]) begin
			rx_en_r <= 1'b1;
		end
	end

	// Transmitter enable state; enabling raises both tx flags at once when the shifter is idle and no break is pending or active
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_en_r <= 1'b0;
		end else if (tx_off) begin
			tx_en_r <= 1'b0;
		end else if (tx_on) begin
			tx_en_r <= 1'b1;
		end
	end

	// Receive holding register; a disabled receiver drops incoming chars
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_hold_r <= '0;
		end else if (rx_take && !rx_off) begin
			rx_hold_r <= rx_char_i;
		end
	end

	// Rx ready; disable clears it, new char wins over a same-cycle read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_char_available_r <= 1'b0;
		end else if (rx_off) begin
			rx_char_available_r <= 1'b0;
		end else if (rx_take) begin
			rx_char_available_r <= 1'b1;
		end else if (rhr_rd) begin
			rx_char_available_r <= 1'b0;
		end
	end

	// Break seen flag, sticky until clear-status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brk_r <= 1'b0;
		end else begin
			brk_r <= keep_or_set(rx_break_evt_i, brk_r, clr_sta);
		end
	end

	// Overrun; a read in the landing cycle frees the slot, so no overrun
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_r <= 1'b0;
		end else begin
			ovr_r <= keep_or_set(rx_take && rx_char_available_r && !rhr_rd, ovr_r, clr_sta);
		end
	end

	// Framing error flag, sticky until clear-status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frm_r <= 1'b0;
		end else begin
			frm_r <= keep_or_set(rx_frame_err_i, frm_r, clr_sta);
		end
	end

	// Parity error flag, sticky until clear-status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			par_r <= 1'b0;
		end else begin
			par_r <= keep_or_set(rx_parity_err_i, par_r, clr_sta);
		end
	end

	// Modem change flag; clear-status clears it as well
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mdm_r <= 1'b0;
		end else begin
			mdm_r <= keep_or_set(modem_delta_i, mdm_r, clr_sta);
		end
	end

	// Timeout flag: expiry sets it, restart clears it, zero value forces zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmo_r <= 1'b0;
		end else if (rx_timeout_evt_i && !timeout_zero_i) begin
			tmo_r <= 1'b1;
		end else if (tmo_restart || timeout_zero_i) begin
			tmo_r <= 1'b0;
		end
	end

	// Transmit holding; handed to the shifter only when it is ready
	always_ff @(posedge clk_i) begin
		if (rst_i || tx_off) begin
			tx_full_r <= 1'b0;
			tx_hold_r <= '0;
		end else if (thr_wr) begin
			tx_full_r <= 1'b1;
			tx_hold_r <= wb_dat_i[uish_pkg::CHW-1:0];
		end else if (tx_take) begin
			tx_full_r <= 1'b0;
		end
	end
	assign tx_char_valid_o = tx_full_r;
	assign char_to_send_o  = tx_hold_r;

	// Break request waits for the shifter to drain
	always_ff @(posedge clk_i) begin
		if (rst_i || tx_off) begin
			brk_pend_r <= 1'b0;
		end else if (cmd_wr && wb_dat_i[uish_pkg::C_STTBRK] && !tx_break_active_i) begin
			brk_pend_r <= 1'b1;
		end else if (tx_break_active_i) begin
			brk_pend_r <= 1'b0;
		end
	end

	// Live status view; reset value follows from disabled transmitter and
	// idle DMA ends, so the read shows STATUS_RST when DMA end signals idle high
	always_comb begin
		status                      = '0;
		status[uish_pkg::B_RX_CHAR_AVAILABLE]   = rx_char_available_r;
		status[uish_pkg::B_BRK]     = brk_r;
		status[uish_pkg::B_OVR]     = ovr_r;
		status[uish_pkg::B_FRM]     = frm_r;
		status[uish_pkg::B_PAR]     = par_r;
		status[uish_pkg::B_TMO]     = tmo_r;
		status[uish_pkg::B_MDM]     = mdm_r;
		status[uish_pkg::B_TX_HOLDING_FREE]   = tx_en_r && !tx_full_r && !brk_pend_r;
		status[uish_pkg::B_TXE]     = tx_en_r && !tx_full_r && !tx_shift_busy_i
			&& !tx_break_active_i && !brk_pend_r;
		status[uish_pkg::B_RXDMA]   = rx_dma_done_i;
		status[uish_pkg::B_TXDMA]   = tx_dma_done_i;
	end

	// Registered read data; write-only and command words read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit(wb_adr_i, uish_pkg::OFS_IMASK)) begin
			rd_nxt[uish_pkg::NSRC-1:0] = mask_r;
		end else if (hit(wb_adr_i, uish_pkg::OFS_STATUS)) begin
			rd_nxt[uish_pkg::NSRC-1:0] = status;
		end else if (hit(wb_adr_i, uish_pkg::OFS_RXHOLD)) begin
			rd_nxt[uish_pkg::CHW-1:0] = rx_hold_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// Commands to the serial engine; break start waits for holding and shifter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			break_start_o   <= 1'b0;
			break_stop_o    <= 1'b0;
			timeout_start_o <= 1'b0;
		end else begin
			break_start_o   <= brk_pend_r && !tx_full_r && !tx_shift_busy_i;
			break_stop_o    <= cmd_wr && wb_dat_i[uish_pkg::C_STPBRK];
			timeout_start_o <= tmo_restart;
		end
	end

	// Interrupt level, registered so it never glitches; one cycle behind status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & mask_r);
		end
	end
	assign rx_enabled_o = rx_en_r;
	assign tx_enabled_o = tx_en_r;

	// Byte lanes are not decoded: partial writes act as full-word writes
	logic unused_ok;
	assign unused_ok = |wb_sel_i;
endmodule // uish_top

// [tb/uish_checker.sv]
// Checker of bus answers, engine commands, transmit holding and interrupt gating
`timescale 1ns/1ps
module uish_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        tx_char_valid_o,
	input wire logic [8:0]  char_to_send_o,
	input wire logic        tx_shift_ready_i,
	input wire logic        rx_enabled_o,
	input wire logic        tx_enabled_o,
	input wire logic        timeout_start_o,
	input wire logic        irq_o
);
	logic tk, wc, wt, mp;
	// A request counts once, on the edge before its answer
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wc = tk && wb_we_i && wb_adr_i == uish_pkg::OFS_CTRL;
	assign wt = tk && wb_we_i && wb_adr_i == uish_pkg::OFS_TXHOLD;
	// Gaps in the map, such as 0x04, must answer with an error
	assign mp = wb_adr_i inside {uish_pkg::OFS_CTRL, uish_pkg::OFS_IEN, uish_pkg::OFS_IDIS,
		uish_pkg::OFS_IMASK, uish_pkg::OFS_STATUS, uish_pkg::OFS_RXHOLD, uish_pkg::OFS_TXHOLD};
	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bus_answer_a: assert property (tk && mp |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acked");
	err_answer_a: assert property (tk && !mp |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	tx_enable_a: assert property (wc && wb_dat_i[6] && !wb_dat_i[7] |=> tx_enabled_o)
		else $error("transmitter not enabled");
	tx_disable_a: assert property (wc && wb_dat_i[7] |=> !tx_enabled_o)
		else $error("transmitter not disabled");
	rx_disable_a: assert property (wc && wb_dat_i[5] |=> !rx_enabled_o)
		else $error("receiver not disabled");
	tmo_pulse_a: assert property (wc && wb_dat_i[11] |=> timeout_start_o ##1 !timeout_start_o)
		else $error("timeout start not one pulse");
	tx_load_a: assert property (wt && tx_enabled_o && !tx_char_valid_o |=> tx_char_valid_o
		&& {23'h0, char_to_send_o} == ($past(wb_dat_i) & 32'h000001FF)) else $error("char not held");
	tx_drain_a: assert property (tx_char_valid_o && tx_shift_ready_i && !wt |=> !tx_char_valid_o)
		else $error("holding not freed");
	irq_off_a: assert property (tk && wb_we_i && wb_adr_i == uish_pkg::OFS_IDIS
		&& wb_dat_i[10:0] == 11'h7FF |-> ##2 !irq_o) else $error("irq stays after full disable");
	cover property (wt && tx_enabled_o);
	cover property (wb_err_o);
	cover property ($rose(irq_o));
endmodule // uish_checker
bind uish_top uish_checker chk_u (.*);

// [tb/tb_usart_irq_status_holding.sv]
// Self-checking bench of the interrupt, status and holding registers
`timescale 1ns/1ps
module tb_usart_irq_status_holding;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00, ev = 8'h60;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [8:0]  rx_char_i = 9'h000, char_to_send_o;
	logic        rx_char_valid_i = 1'b0, tx_shift_ready_i = 1'b0, tx_shift_busy_i = 1'b0;
	logic        tx_break_active_i = 1'b0, wb_ack_o, wb_err_o, er, tx_char_valid_o, irq_o;
	logic        rx_enabled_o, tx_enabled_o, break_start_o, break_stop_o, timeout_start_o;
	wire [3:0]   wb_sel_i = 4'hF;
	// One vector feeds the event pulses and levels so table rows can drive them
	wire         rx_frame_err_i = ev[0], rx_parity_err_i = ev[1], rx_break_evt_i = ev[2];
	wire         rx_timeout_evt_i = ev[3], modem_delta_i = ev[4], rx_dma_done_i = ev[5];
	wire         tx_dma_done_i = ev[6], timeout_zero_i = ev[7];
	int          checks = 0, errors = 0, i;
	// Event vector beside the status it gives, transmitter enabled and idle
	logic [39:0] rows [8] = '{40'h01_00000242, 40'h02_00000282, 40'h04_00000206,
		40'h08_00000302, 40'h10_00000602, 40'h20_0000020A, 40'h40_00000212, 40'h88_00000202};
	uish_top dut (.*);
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			errors++;
			$display("[ERR] %0t got 0x%h exp 0x%h", $time, g, x);
		end
	endtask
	// Classic cycle: hold everything until ack or err is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		{wb_adr_i, wb_dat_i} <= {a, d};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
				break;
		end
		if (n == 20)
			chk(32'h0, 32'h1);
		if (n == 20)
			wrap_up();
		rd = wb_dat_o;
		er = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] x);
		wb(1'b0, uish_pkg::OFS_STATUS, 32'h0);
		chk(rd & m, x);
	endtask
	// One-cycle event pulse; DMA and zero-timeout levels stay up
	task automatic pulse(input logic [7:0] e, input logic [9:0] c);
		@(posedge clk_i);
		ev <= e;
		{rx_char_valid_i, rx_char_i} <= c;
		@(posedge clk_i);
		ev <= e & 8'hE0;
		rx_char_valid_i <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values; status ignores the write, a gap in the map is refused
		wb(1'b1, uish_pkg::OFS_STATUS, 32'hFFFFFFFF);
		stat(32'hFFFFFFFF, 32'h018);
		wb(1'b0, uish_pkg::OFS_IMASK, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk({31'h0, er}, 32'h1);
		ev <= 8'h00;
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h050);
		stat(32'hFFFFFFFF, 32'h202);
		$display("reset test done");
		// Each event alone, then clear-status with start-timeout
		for (i = 0; i < 8; i++) begin
			pulse(rows[i][39:32], 10'h000);
			stat(32'hFFFFFFFF, rows[i][31:0]);
			ev <= 8'h00;
			wb(1'b1, uish_pkg::OFS_CTRL, 32'h900);
			stat(32'hFFFFFFFF, 32'h202);
		end
		$display("status rows done");
		// Mask bits as {mask, irq}: partial disable, gating, clear
		wb(1'b1, uish_pkg::OFS_IEN, 32'h0C0);
		wb(1'b1, uish_pkg::OFS_IDIS, 32'h080);
		pulse(8'h01, 10'h000);
		wb(1'b0, uish_pkg::OFS_IMASK, 32'h0);
		chk({rd[30:0], irq_o}, 32'h081);
		wb(1'b1, uish_pkg::OFS_IDIS, 32'h7FF);
		wb(1'b0, uish_pkg::OFS_IMASK, 32'h0);
		chk({rd[30:0], irq_o}, 32'h000);
		wb(1'b1, uish_pkg::OFS_IEN, 32'h040);
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h100);
		wb(1'b0, uish_pkg::OFS_IMASK, 32'h0);
		chk({rd[30:0], irq_o}, 32'h080);
		$display("irq test done");
		// Receive: nine-bit char, holding read, overrun, disable
		pulse(8'h00, 10'h3A5);
		stat(32'h021, 32'h001);
		wb(1'b0, uish_pkg::OFS_RXHOLD, 32'h0);
		chk(rd, 32'h1A5);
		pulse(8'h00, 10'h25A);
		pulse(8'h00, 10'h2C3);
		stat(32'h021, 32'h021);
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h120);
		stat(32'h021, 32'h000);
		$display("rx test done");
		// Transmit: holding, hand-off to a busy shifter, break, disable
		wb(1'b1, uish_pkg::OFS_TXHOLD, 32'h155);
		chk({22'h0, tx_char_valid_o, char_to_send_o}, 32'h355);
		stat(32'h202, 32'h000);
		{tx_shift_ready_i, tx_shift_busy_i} <= 2'b11;
		@(posedge clk_i);
		tx_shift_ready_i <= 1'b0;
		stat(32'h202, 32'h002);
		{tx_shift_busy_i, tx_break_active_i} <= 2'b01;
		stat(32'h200, 32'h000);
		tx_break_active_i <= 1'b0;
		stat(32'h200, 32'h200);
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h080);
		wb(1'b1, uish_pkg::OFS_TXHOLD, 32'h0AA);
		stat(32'h202, 32'h000);
		chk({31'h0, tx_char_valid_o}, 32'h0);
		// Break request: pending break holds tx ready low, stop command raises break_stop_o
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h040);
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h200);
		@(posedge clk_i);
		chk({31'h0, break_start_o}, 32'h1);
		stat(32'h002, 32'h000);
		tx_break_active_i <= 1'b1;
		stat(32'h202, 32'h002);
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h400);
		chk({31'h0, break_stop_o}, 32'h1);
		tx_break_active_i <= 1'b0;
		wb(1'b1, uish_pkg::OFS_CTRL, 32'h20C);
		chk({31'h0, tx_enabled_o}, 32'h0);
		$display("tx test done");
		wrap_up();
	end
endmodule // tb_usart_irq_status_holding
